// file: rtl/wsc_pkg.sv
// Package for the watchdog and sleep/wake control block
package wsc_pkg;
    // Register offsets
    localparam logic [15:0] OPTION_OFS = 16'h0081;
    localparam logic [15:0] OPTION_OFS_ALT = 16'h0181;
    localparam logic [15:0] CONFIG_OFS = 16'h2007;
    localparam logic [15:0] STATUS_OFS = 16'h0003;
    // Field positions
    localparam int CFG_WDT_EN_BIT = 2;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_LSB = 0;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;
    // Reset values
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] CONFIG_RST = 8'hff;
    // Interrupt vector
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // Core request group
    typedef struct packed {
        logic clear_watchdog_instr;
        logic sleep;
    } wsc_instr_t;

    typedef enum logic [1:0] {
        WSC_RUN,
        WSC_SLEEP,
        WSC_WAKE
    } wsc_state_t;
endpackage

// file: rtl/wsc_top.sv
// Watchdog timer with sleep entry and wake-up control
// Register map
//   Option register at two aliases, same storage
//   Configuration word, bit 2 enables the watchdog
//   Status, read only: bit 4 timeout_flag, bit 3 powerdown_flag
//   Unmapped reads return zero, unmapped writes are dropped
//
// Register bus timing
//   Write takes effect on the strobe's clock edge
//   Read data stand for one cycle after the read strobe
//   Strobes may follow each other with no gap
//
// Watchdog timing
//   One count per oscillator tick, ticks arrive as pulses
//   Base period is 2^WDT_BITS ticks
//   With the postscaler assigned: 2^ratio base periods
//   Clear and sleep restart the base counter, and the postscaler only when assigned
//   A clear in the cycle of a time-out wins over it
//
// Sleep and wake
//   Sleep with no enabled pending source enters power-down
//   Oscillator driver off and pins held while asleep
//   Wake pulse comes one cycle after the wake cause
//   Oscillator and pins come back one cycle after wake
//   Branch pulse comes with them when global enable is set and a wake source still pends
//
// Sequencer
//   Run: core executes, clear and sleep requests taken
//   Sleep: oscillator off, waits for a wake cause
//   Wake: one cycle in which the prefetched instruction
//   issues and the branch decision is made
//
// Interrupt sources
//   Each source brings a flag, an enable and a clock-free mark
//   While running, enabled flags stop a sleep from taking hold
//   While asleep, only clock-free sources can wake the core
//   The global enable only decides the branch after a wake
//
// Status flags after each event (timeout_flag, powerdown_flag)
//   Power-up reset            1 1
//   Sleep entered             1 0
//   Watchdog reset in run     0 unchanged
//   Watchdog wake from sleep  0 0
//   Interrupt wake            1 0
//   Master clear              unchanged
//
// Resets
//   arst_n_i is the power-up reset, both status flags set
//   Master clear pin gives a device reset pulse
//   Master clear leaves the status flags as they stand
//   A watchdog reset pulses both reset outputs together
//
// Parameters
//   WDT_BITS: width of the base counter, sets the base period
//   RATIO_BITS: width of the ratio field in the option register
//   SRC_COUNT: number of interrupt sources watched for wake
//
// Hazards
//   A sleep and an enabled flag in one cycle: the flag wins and
//   the sleep is a no-op, matching a flag raised just before it
//   A clock-free flag raised one cycle after sleep entry wakes at once,
//   with the sleep's flag and counter effects already in place
//   Writing the option register mid-count keeps both counts;
//   software should clear the watchdog after changing the ratio
//
// Limitations
//   Oscillator ticks must already be in the core clock domain
//   The caller holds the core in reset on device_reset_o
//   Option and configuration survive a device reset; the
//   core reloads them if it needs fresh values
//   Clock-free sources are flagged per input, not fixed here
//
`timescale 1ns/1ps
module wsc_top #(
    parameter int WDT_BITS = 8,
    parameter int RATIO_BITS = 3,
    parameter int SRC_COUNT = 4
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Watchdog oscillator tick, one pulse per tick, this clock domain
    input wire logic wdt_rc_tick_i,
    // Core side: reset pin level and one-cycle instruction strobes
    input wire logic master_clear_pin_i,
    input wire wsc_pkg::wsc_instr_t instr_i,
    // Interrupt sources as levels
    input wire logic [SRC_COUNT-1:0] irq_flag_i,
    input wire logic [SRC_COUNT-1:0] irq_enable_i,
    input wire logic [SRC_COUNT-1:0] irq_no_clock_need_i,
    input wire logic global_irq_enable_i,
    // Register bus, read data one cycle after the strobe
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Reset, wake and power control to the core
    output logic wdt_reset_o,
    output logic device_reset_o,
    output logic wake_o,
    output logic osc_drive_en_o,
    output logic io_hold_o,
    output logic irq_branch_o,
    output logic clear_global_irq_o,
    output logic [12:0] vector_o,
    // Status flags and sleep state
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output logic sleeping_o
);
    // Whole state of the block as one packed struct
    typedef struct packed {
        // Sequencer state
        wsc_pkg::wsc_state_t st;
        // Mirror of the sequencer state, so sleeping_o is a flop
        logic asleep;
        // Watchdog base counter, one step per oscillator tick
        logic [WDT_BITS-1:0] wdt_cnt;
        // Postscaler, counts base overflows when assigned
        logic [(1<<RATIO_BITS)-1:0] post_cnt;
        // Software-visible registers
        logic [7:0] option;
        logic [7:0] config_w;
        // Status flags, both set at power-up
        logic to_flag;
        logic pd_flag;
        // Read data, zero except the cycle after a read
        logic [7:0] rdata;
        // One-cycle pulses to the core; dev_reset stays high while the master clear pin is held
        logic wdt_reset;
        logic dev_reset;
        logic wake;
        // Levels that hold while asleep
        logic osc_en;
        logic io_hold;
        // Vector decision after a wake
        logic branch;
        logic clr_gie;
        logic [12:0] vector;
    } wsc_state_all_t;

    wsc_state_all_t s_reg;
    wsc_state_all_t s_next;
    // Watchdog on, by the configuration word
    logic wdt_enabled;
    // Postscaler owned by the watchdog rather than the timer
    logic postscale_to_wdt;
    // Postscaler ratio field
    logic [RATIO_BITS-1:0] ratio;
    // Per-source wake request and their union
    logic [SRC_COUNT-1:0] wake_src;
    logic wake_pending;
    // Base counter wraps on this tick
    logic wdt_ovf;
    // Postscaler at its terminal count
    logic post_hit;
    // Time-out event, one cycle
    logic timeout;

    // Address decode used for both reads and writes
    function automatic logic hits_option(input logic [15:0] a);
        return a == wsc_pkg::OPTION_OFS || a == wsc_pkg::OPTION_OFS_ALT;
    endfunction

    // Postscaler terminal count for a ratio field value; sized to the
    // counter so the compare is exact at every ratio
    function automatic logic [(1<<RATIO_BITS)-1:0] ratio_limit(
        input logic [RATIO_BITS-1:0] r);
        logic [(1<<RATIO_BITS)-1:0] lim;
        lim = '0;
        for (int i = 0; i < (1 << RATIO_BITS); i++) begin
            lim[i] = (i < int'(r));
        end
        return lim;
    endfunction

    // Per-source wake qualification; only sources needing no core clock
    // count while asleep, the global enable plays no part here
    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : g_src
            assign wake_src[g] = irq_flag_i[g] & irq_enable_i[g] &
                (irq_no_clock_need_i[g] | (s_reg.st == wsc_pkg::WSC_RUN));
        end
    endgenerate

    // Configuration decode
    assign wdt_enabled = s_reg.config_w[wsc_pkg::CFG_WDT_EN_BIT];
    assign postscale_to_wdt = s_reg.option[wsc_pkg::OPT_ASSIGN_BIT];
    assign ratio = s_reg.option[wsc_pkg::OPT_RATIO_LSB +: RATIO_BITS];
    assign wake_pending = |wake_src;
    // Base period is the full wrap of the counter; the postscaler then
    // divides the overflows by 2^ratio
    // A small WDT_BITS shortens the base period for simulation; the
    // postscaler path stays the same
    assign wdt_ovf = wdt_rc_tick_i && (&s_reg.wdt_cnt);
    assign post_hit = s_reg.post_cnt == ratio_limit(ratio);
    assign timeout = wdt_enabled && wdt_ovf &&
        (!postscale_to_wdt || post_hit);

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        s_next.wdt_reset = 1'b0;
        s_next.dev_reset = 1'b0;
        s_next.wake = 1'b0;
        s_next.branch = 1'b0;
        s_next.clr_gie = 1'b0;

        // Watchdog counts on RC ticks in every state, even asleep
        // Counting stops only when the configuration disables it or the master clear pin is held
        if (wdt_rc_tick_i && wdt_enabled) begin
            s_next.wdt_cnt = s_reg.wdt_cnt + 1'b1;
            if (wdt_ovf && postscale_to_wdt) begin
                s_next.post_cnt = post_hit ? '0 : s_reg.post_cnt + 1'b1;
            end
        end

        // Register writes; instruction clears never touch option bits
        // Status has no write path: its flags only follow events
        if (reg_wr_i) begin
            if (hits_option(reg_addr_i)) begin
                s_next.option = reg_wdata_i;
            end else if (reg_addr_i == wsc_pkg::CONFIG_OFS) begin
                s_next.config_w = reg_wdata_i;
            end
        end

        // Register reads, unmapped addresses read zero
        // Status bits other than the two flags read as zero
        if (reg_rd_i) begin
            if (hits_option(reg_addr_i)) begin
                s_next.rdata = s_reg.option;
            end else if (reg_addr_i == wsc_pkg::CONFIG_OFS) begin
                s_next.rdata = s_reg.config_w;
            end else if (reg_addr_i == wsc_pkg::STATUS_OFS) begin
                s_next.rdata[wsc_pkg::STAT_TO_BIT] = s_reg.to_flag;
                s_next.rdata[wsc_pkg::STAT_PD_BIT] = s_reg.pd_flag;
            end
        end

        case (s_reg.st)
            wsc_pkg::WSC_RUN: begin
                if (instr_i.clear_watchdog_instr) begin
                    s_next.wdt_cnt = '0;
                    if (postscale_to_wdt) begin
                        s_next.post_cnt = '0;
                    end
                end
                // A clear or a real sleep in the time-out cycle wins:
                // both restart the count before it can bite
                if (timeout && !instr_i.clear_watchdog_instr &&
                    !(instr_i.sleep && !wake_pending)) begin
                    s_next.wdt_reset = 1'b1;
                    s_next.dev_reset = 1'b1;
                    s_next.to_flag = 1'b0;
                    s_next.wdt_cnt = '0;
                    s_next.post_cnt = '0;
                end else if (instr_i.sleep && !wake_pending) begin
                    s_next.wdt_cnt = '0;
                    if (postscale_to_wdt) begin
                        s_next.post_cnt = '0;
                    end
                    s_next.pd_flag = 1'b0;
                    s_next.to_flag = 1'b1;
                    s_next.osc_en = 1'b0;
                    s_next.io_hold = 1'b1;
                    s_next.st = wsc_pkg::WSC_SLEEP;
                end
                // A sleep with an enabled flag already pending falls
                // through here untouched, acting as a no-op
            end
            wsc_pkg::WSC_SLEEP: begin
                if (timeout) begin
                    s_next.to_flag = 1'b0;
                    s_next.wake = 1'b1;
                    s_next.wdt_cnt = '0;
                    s_next.post_cnt = '0;
                    s_next.st = wsc_pkg::WSC_WAKE;
                end else if (wake_pending) begin
                    // Sleep entry already took full effect
                    s_next.wake = 1'b1;
                    s_next.st = wsc_pkg::WSC_WAKE;
                end
            end
            wsc_pkg::WSC_WAKE: begin
                // Core runs the prefetched instruction, then this
                // decides whether to take the vector
                // The cause is sampled again here, so a flag cleared
                // meanwhile gives no branch
                s_next.osc_en = 1'b1;
                s_next.io_hold = 1'b0;
                if (global_irq_enable_i && wake_pending) begin
                    s_next.branch = 1'b1;
                    s_next.clr_gie = 1'b1;
                    s_next.vector = wsc_pkg::IRQ_VECTOR;
                end
                s_next.st = wsc_pkg::WSC_RUN;
            end
            default: begin
                // Unused encoding: back to run rather than lock up
                s_next.st = wsc_pkg::WSC_RUN;
            end
        endcase

        // Master clear wins over the sequencer, wake and branch (not wdt_reset) and restarts the core,
        // flags follow the reset-pin convention (left unchanged here)
        if (master_clear_pin_i) begin
            s_next.dev_reset = 1'b1;
            s_next.wake = 1'b0;
            s_next.branch = 1'b0;
            s_next.clr_gie = 1'b0;
            s_next.osc_en = 1'b1;
            s_next.io_hold = 1'b0;
            s_next.wdt_cnt = '0;
            s_next.post_cnt = '0;
            // Counters restart so a held pin never lets the watchdog
            // bite on release
            s_next.st = wsc_pkg::WSC_RUN;
        end

        // Registered copy of the sleep state drives sleeping_o
        s_next.asleep = (s_next.st == wsc_pkg::WSC_SLEEP);
    end

    // State register; power-up sets both status flags
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            s_reg.st <= wsc_pkg::WSC_RUN;
            s_reg.option <= wsc_pkg::OPTION_RST;
            s_reg.config_w <= wsc_pkg::CONFIG_RST;
            s_reg.to_flag <= 1'b1;
            s_reg.pd_flag <= 1'b1;
            s_reg.osc_en <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    // Every output is a register field, no logic after the flops
    assign reg_rdata_o = s_reg.rdata;
    assign wdt_reset_o = s_reg.wdt_reset;
    assign device_reset_o = s_reg.dev_reset;
    assign wake_o = s_reg.wake;
    assign osc_drive_en_o = s_reg.osc_en;
    assign io_hold_o = s_reg.io_hold;
    assign irq_branch_o = s_reg.branch;
    assign clear_global_irq_o = s_reg.clr_gie;
    assign vector_o = s_reg.vector;
    assign timeout_flag_o = s_reg.to_flag;
    assign powerdown_flag_o = s_reg.pd_flag;
    assign sleeping_o = s_reg.asleep;
endmodule

// file: verif/test_wsc_top.sv
// Self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
$display("Error %0t got %h exp %h", $time, a, b); end end
module test_wsc_top;
    logic core_clk_i = 0, arst_n_i = 0, wdt_rc_tick_i;
    logic master_clear_pin_i = 0, global_irq_enable_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0;
    wsc_pkg::wsc_instr_t instr_i = '0;
    logic [3:0] irq_flag_i = 4'h0, irq_enable_i = 4'h0;
    logic [3:0] irq_no_clock_need_i = 4'h0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic wdt_reset_o, device_reset_o, wake_o, osc_drive_en_o, io_hold_o;
    logic irq_branch_o, clear_global_irq_o, timeout_flag_o;
    logic powerdown_flag_o, sleeping_o;
    logic [12:0] vector_o;
    int bad_count = 0, n_tests = 0, n_rst = 0, hit, base;
    always #4 core_clk_i = ~core_clk_i;
    wsc_rc_osc_model #(.PERIOD(4)) rc (.core_clk_i, .arst_n_i,
        .tick_o(wdt_rc_tick_i));
    wsc_top #(.WDT_BITS(2)) dut (.core_clk_i, .arst_n_i, .wdt_rc_tick_i,
        .master_clear_pin_i, .instr_i, .irq_flag_i, .irq_enable_i,
        .irq_no_clock_need_i, .global_irq_enable_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .wdt_reset_o,
        .device_reset_o, .wake_o, .osc_drive_en_o, .io_hold_o,
        .irq_branch_o, .clear_global_irq_o, .vector_o, .timeout_flag_o,
        .powerdown_flag_o, .sleeping_o);
    // Count reset pulses so unexpected bites show up later
    always @(posedge core_clk_i) if (device_reset_o === 1'b1) n_rst++;
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, input logic [7:0] m, e);
        @(posedge core_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o & m, e)
    endtask
    task automatic op(input logic s, c);
        @(posedge core_clk_i);
        instr_i <= '{clear_watchdog_instr: c, sleep: s};
        @(posedge core_clk_i);
        instr_i <= '0;
        #1;
    endtask
    task automatic irq(input logic [3:0] f, e, n, input logic g);
        @(posedge core_clk_i);
        {irq_flag_i, irq_enable_i, irq_no_clock_need_i} <= {f, e, n};
        global_irq_enable_i <= g;
    endtask
    // Bounded wait for a reset or a wake pulse
    task automatic wt(input logic r, output int n);
        for (n = 1; n < 400; n++) begin
            @(posedge core_clk_i);
            #1;
            if ((r ? device_reset_o : wake_o) === 1'b1) break;
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        final_report;
    end
    // Register map, no-op sleep, then sleeps ended by each wake cause
    initial begin
        repeat (2) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rreg(wsc_pkg::OPTION_OFS, 8'hff, 8'hff);
        rreg(wsc_pkg::CONFIG_OFS, 8'hff, 8'hff);
        rreg(wsc_pkg::STATUS_OFS, 8'h18, 8'h18);
        rreg(16'h0055, 8'hff, 8'h00);
        wreg(wsc_pkg::OPTION_OFS, 8'h00);
        op(1'b0, 1'b1);
        rreg(wsc_pkg::OPTION_OFS_ALT, 8'hff, 8'h00);
        irq(4'h1, 4'h1, 4'h0, 1'b0);
        op(1'b1, 1'b0);
        `CHK({sleeping_o, powerdown_flag_o}, 2'b01)
        wt(1'b1, hit);
        `CHK({hit < 400, wdt_reset_o, timeout_flag_o}, 3'b110)
        wreg(wsc_pkg::OPTION_OFS, 8'h00);
        irq(4'h0, 4'h0, 4'h0, 1'b1);
        op(1'b0, 1'b1);
        op(1'b1, 1'b0);
        `CHK({sleeping_o, powerdown_flag_o, timeout_flag_o}, 3'b101)
        `CHK({osc_drive_en_o, io_hold_o}, 2'b01)
        irq(4'h1, 4'h1, 4'h0, 1'b1);
        irq(4'h1, 4'h0, 4'h1, 1'b1);
        @(posedge core_clk_i);
        #1 `CHK(sleeping_o, 1'b1)
        irq(4'h1, 4'h1, 4'h1, 1'b1);
        wt(1'b0, hit);
        @(posedge core_clk_i);
        #1 `CHK({irq_branch_o, clear_global_irq_o}, 2'b11)
        `CHK(vector_o, wsc_pkg::IRQ_VECTOR)
        irq(4'h0, 4'h2, 4'h2, 1'b0);
        op(1'b0, 1'b1);
        op(1'b1, 1'b0);
        irq(4'h2, 4'h2, 4'h2, 1'b0);
        wt(1'b0, hit);
        `CHK({hit < 400, powerdown_flag_o}, 2'b10)
        @(posedge core_clk_i);
        #1 `CHK(irq_branch_o, 1'b0)
        irq(4'h0, 4'h0, 4'h0, 1'b0);
        op(1'b0, 1'b1);
        op(1'b1, 1'b0);
        wt(1'b0, hit);
        `CHK({hit < 400, wdt_reset_o, timeout_flag_o}, 3'b100)
        base = n_rst;
        repeat (20) op(1'b0, 1'b1);
        `CHK(n_rst, base)
        wreg(wsc_pkg::CONFIG_OFS, 8'hfb);
        repeat (100) @(posedge core_clk_i);
        `CHK(n_rst, base)
        wreg(wsc_pkg::CONFIG_OFS, 8'hff);
        wreg(wsc_pkg::OPTION_OFS, 8'h09);
        op(1'b0, 1'b1);
        rreg(wsc_pkg::OPTION_OFS, 8'hff, 8'h09);
        wt(1'b1, hit);
        `CHK(hit > 20 && hit < 400, 1'b1)
        op(1'b0, 1'b1);
        op(1'b1, 1'b0);
        @(posedge core_clk_i);
        master_clear_pin_i <= 1'b1;
        @(posedge core_clk_i);
        master_clear_pin_i <= 1'b0;
        #1 `CHK({device_reset_o, wake_o}, 2'b10)
        final_report;
    end
endmodule

// file: verif/wsc_rc_osc_model.sv
// Free-running watchdog oscillator model
`timescale 1ns/1ps
module wsc_rc_osc_model #(
    parameter int PERIOD = 4
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    output logic tick_o
);
    int cnt;
    // Ticks even while the core sleeps, as the real source does
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 0;
            tick_o <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            tick_o <= (cnt == PERIOD - 1);
        end
    end
endmodule

// file: verif/wsc_top_monitor.sv
// Checker for the sleep, wake and reset outputs
`timescale 1ns/1ps
module wsc_top_monitor #(
    parameter int SRC_COUNT = 4
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic master_clear_pin_i,
    input wire wsc_pkg::wsc_instr_t instr_i,
    input wire logic [SRC_COUNT-1:0] irq_flag_i,
    input wire logic [SRC_COUNT-1:0] irq_enable_i,
    input wire logic [SRC_COUNT-1:0] irq_no_clock_need_i,
    input wire logic wdt_reset_o,
    input wire logic device_reset_o,
    input wire logic wake_o,
    input wire logic osc_drive_en_o,
    input wire logic io_hold_o,
    input wire logic irq_branch_o,
    input wire logic clear_global_irq_o,
    input wire logic [12:0] vector_o,
    input wire logic timeout_flag_o,
    input wire logic powerdown_flag_o,
    input wire logic sleeping_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Enabled request pending; decides sleep against no-op
    logic pend;
    logic waker;
    assign pend = |(irq_flag_i & irq_enable_i);
    assign waker = |(irq_flag_i & irq_enable_i & irq_no_clock_need_i);
    sequence s_asleep;
        sleeping_o && !powerdown_flag_o && timeout_flag_o;
    endsequence
    sequence s_resumed;
        osc_drive_en_o && !io_hold_o && !sleeping_o;
    endsequence
    a_sleep_entry: assert property (
        instr_i.sleep && !pend && osc_drive_en_o && !sleeping_o &&
        !master_clear_pin_i |=> s_asleep) else $error("sleep entry wrong");
    a_sleep_noop: assert property (
        instr_i.sleep && pend && osc_drive_en_o && !master_clear_pin_i
        |=> !sleeping_o && $stable(powerdown_flag_o))
        else $error("sleep not a no-op");
    a_pin_hold: assert property (
        sleeping_o |-> io_hold_o && !osc_drive_en_o)
        else $error("pins not held asleep");
    a_wdt_reset: assert property (
        wdt_reset_o |-> device_reset_o && !timeout_flag_o)
        else $error("watchdog reset wrong");
    a_wake_seq: assert property (
        wake_o |=> s_resumed) else $error("wake sequence wrong");
    a_irq_wake: assert property (
        sleeping_o && waker && !wake_o && !master_clear_pin_i |=> wake_o)
        else $error("no wake on enabled source");
    a_branch_vec: assert property (
        irq_branch_o |-> clear_global_irq_o && $past(wake_o) &&
        vector_o == wsc_pkg::IRQ_VECTOR) else $error("branch wrong");
    a_master_clear_pin_reset: assert property (
        master_clear_pin_i |=> device_reset_o) else $error("no pin reset");
endmodule

bind wsc_top wsc_top_monitor #(.SRC_COUNT(SRC_COUNT)) u_mon (
    .core_clk_i, .arst_n_i, .master_clear_pin_i, .instr_i, .irq_flag_i,
    .irq_enable_i, .irq_no_clock_need_i, .wdt_reset_o, .device_reset_o,
    .wake_o, .osc_drive_en_o, .io_hold_o, .irq_branch_o,
    .clear_global_irq_o, .vector_o, .timeout_flag_o, .powerdown_flag_o,
    .sleeping_o);
